/* File: verilog/vxr_regs.sv */
// virtualization exit-information encoder and global control registers
// assumes register accesses arrive one per cycle as single-cycle strobes
`timescale 1ns/1ps
`default_nettype none
`include "vxr_defines.svh"
module vxr_regs
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // register access port
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_addr,
   input wire logic [63:0] i_reg_wdata,
   output logic [63:0] o_reg_rdata,
   output logic o_reg_rvalid,
   output logic o_protection_fault,
   // core state and events
   input wire logic i_virt_enable_bit,
   input wire logic i_init_event,
   input wire logic i_secure_init_instr,
   input wire logic i_key_unlock,
   // exit sources
   input wire vxr_pkg::vxr_ipi_fail_s i_ipi_fail,
   input wire vxr_pkg::vxr_noaccel_s i_noaccel,
   // exit report
   output logic o_exit_valid,
   output logic [1:0] o_exit_kind,
   output logic [63:0] o_exit_detail_first,
   output logic [63:0] o_exit_detail_second,
   // control outputs
   output logic o_debug_disable,
   output logic o_init_redirect,
   output logic o_addr_wrap_mask_off,
   output logic o_virt_enable_mbz,
   output logic o_numeric_error_ignore
);
   vxr_pkg::vxr_state_s state_reg;
   vxr_pkg::vxr_state_s state_next;
   logic hit_ctl;
   logic hit_nerr;
   logic [31:0] cause;

   // ---------------------------------------------
   // next-state logic
   // ---------------------------------------------
   // all decisions in one process; an ipi failure beats a noaccel exit in the same cycle
   always_comb
   begin
      state_next = state_reg;
      state_next.exit_pulse = 1'b0;
      state_next.fault = 1'b0;
      state_next.rvalid = 1'b0;
      hit_ctl = (i_reg_addr == `VXR_ADDR_GLOBAL_CTL);
      hit_nerr = (i_reg_addr == `VXR_ADDR_NERR_IGN);
      cause = `VXR_CAUSE_BAD_TYPE;
      // cause priority: type, then target, then page, then not running
      if (i_ipi_fail.level_trig || i_ipi_fail.bad_dest_type)
      begin
         cause = `VXR_CAUSE_BAD_TYPE;
      end
      else if ((i_ipi_fail.logical_mode && !i_ipi_fail.shorthand && i_ipi_fail.target > `VXR_MAX_CLUSTER)
               || (!i_ipi_fail.logical_mode && i_ipi_fail.target > `VXR_MAX_PHYS)
               || i_ipi_fail.entry_missing)
      begin
         cause = `VXR_CAUSE_BAD_TGT;
      end
      else if (i_ipi_fail.bad_page)
      begin
         cause = `VXR_CAUSE_BAD_PAGE;
      end
      else if (i_ipi_fail.not_running)
      begin
         cause = `VXR_CAUSE_NOT_RUN;
      end
      if (i_ipi_fail.valid)
      begin
         state_next.exit_pulse = 1'b1;
         state_next.exit_kind = vxr_pkg::VXR_EXIT_IPI;
         state_next.info1 = {i_ipi_fail.cmd_high, i_ipi_fail.cmd_low};
         // the index field is reserved, hence zero, for cause 0
         state_next.info2 = {cause, 24'h0, (cause == `VXR_CAUSE_BAD_TYPE) ? 8'h00 : i_ipi_fail.entry_index};
      end
      else if (i_noaccel.valid)
      begin
         state_next.exit_pulse = 1'b1;
         state_next.exit_kind = vxr_pkg::VXR_EXIT_NOACCEL;
         state_next.info1 = {31'h0, i_noaccel.is_write, 20'h0, i_noaccel.offset_hi, 4'h0};
         // vector given for an eoi write or a level-triggered eoi; otherwise zero rather than undefined
         if ((i_noaccel.is_write && i_noaccel.offset_hi == `VXR_EOI_OFFSET) || i_noaccel.eoi_level)
         begin
            state_next.info2 = {56'h0, i_noaccel.isr_top_vector};
         end
         else
         begin
            state_next.info2 = 64'h0;
         end
      end
      // register writes
      if (i_reg_wr && hit_ctl)
      begin
         if ((i_reg_wdata & ~`VXR_CTL_MASK) != 64'h0)
         begin
            state_next.fault = 1'b1;
         end
         else if (i_reg_wdata[`VXR_CTL_DIS_BIT] && !state_reg.ctl[`VXR_CTL_DIS_BIT] && i_virt_enable_bit)
         begin
            state_next.fault = 1'b1;
         end
         else
         begin
            state_next.ctl[2:0] = i_reg_wdata[2:0];
            if (!state_reg.ctl[`VXR_CTL_LOCK_BIT])
            begin
               state_next.ctl[4:3] = i_reg_wdata[4:3];
            end
         end
      end
      else if (i_reg_wr && hit_nerr)
      begin
         if ((i_reg_wdata & ~`VXR_NERR_MASK) != 64'h0)
         begin
            state_next.fault = 1'b1;
         end
         else
         begin
            state_next.nerr = i_reg_wdata[0];
         end
      end
      else if (i_reg_wr)
      begin
         state_next.fault = 1'b1; // unmapped address
      end
      // init clears the disable bit only when unlocked; secure init touches nothing
      if (i_init_event && !state_next.ctl[`VXR_CTL_LOCK_BIT])
      begin
         state_next.ctl[`VXR_CTL_DIS_BIT] = 1'b0;
      end
      // key unlock is the only way to drop the lock
      if (i_key_unlock)
      begin
         state_next.ctl[`VXR_CTL_LOCK_BIT] = 1'b0;
      end
      // reads
      if (i_reg_rd)
      begin
         state_next.rvalid = 1'b1;
         if (hit_ctl)
         begin
            state_next.rdata = {59'h0, state_reg.ctl};
         end
         else if (hit_nerr)
         begin
            state_next.rdata = {63'h0, state_reg.nerr};
         end
         else
         begin
            state_next.rdata = 64'h0;
            state_next.fault = 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // state register
   // ---------------------------------------------
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------
   // outputs straight from flops
   // ---------------------------------------------
   assign o_reg_rdata = state_reg.rdata;
   assign o_reg_rvalid = state_reg.rvalid;
   assign o_protection_fault = state_reg.fault;
   assign o_exit_valid = state_reg.exit_pulse;
   assign o_exit_kind = state_reg.exit_kind;
   assign o_exit_detail_first = state_reg.info1;
   assign o_exit_detail_second = state_reg.info2;
   assign o_debug_disable = state_reg.ctl[`VXR_CTL_DBG_BIT];
   assign o_init_redirect = state_reg.ctl[`VXR_CTL_RINIT_BIT];
   assign o_addr_wrap_mask_off = state_reg.ctl[`VXR_CTL_A20_BIT];
   assign o_virt_enable_mbz = state_reg.ctl[`VXR_CTL_DIS_BIT];
   assign o_numeric_error_ignore = state_reg.nerr;
endmodule
`default_nettype wire

/* File: verilog/vxr_defines.svh */
// constants of the virtualization exit-information and control register bank
// assumes a 64-bit model-specific register port and one core clock
// What this block does
// - ipi exit first word: command high in 63:32, command low in 31:0
// - ipi exit second word: cause code 63:32, entry index 7:0 for causes 1-3
// - cause 0 for level trigger or unsupported destination, index reserved
// - cause 1 when a target's scheduled flag is clear, with its entry index
// - cause 2 for invalid target: cluster above 64, physical above 512, missing
// - cause 3 for invalid backing page address, table chosen by delivery mode
// - un-accelerated register access raises an exit with its exit code
// - same exit on end-of-interrupt when top in-service vector is level triggered
// - bit 32 of first word is one for write, zero for read
// - bits 11:4 hold the accessed offset; the low nibble is always zero
// - on write to offset b0, second word 7:0 holds highest in-service vector
// - control registers stay reachable whatever the enable bit says
// - control bit 0 disables the debug tool and internal debug features
// - control bit 1 turns non-intercepted init into a security exception
// - control bit 2 switches off address-line-twenty masking
// - with lock bit 3 set, writes to bits 3 and 4 are ignored, but setting bit 4 while enable bit is one still faults
// - lock clears only via key unlock, never by init or secure init
// - disable bit 4 makes enable bit must-be-zero; feature id still reports
// - setting disable bit while enable bit is one faults, lock regardless
// - init clears disable bit only when unlocked; secure init never changes it
// - numeric-error-ignore register bit 0 drives the signal, other bits zero
`ifndef VXR_DEFINES_SVH
`define VXR_DEFINES_SVH
`define VXR_ADDR_GLOBAL_CTL 32'hc0010114
`define VXR_ADDR_NERR_IGN 32'hc0010115
`define VXR_CTL_DBG_BIT 0
`define VXR_CTL_RINIT_BIT 1
`define VXR_CTL_A20_BIT 2
`define VXR_CTL_LOCK_BIT 3
`define VXR_CTL_DIS_BIT 4
`define VXR_CTL_MASK 64'h000000000000001f
`define VXR_NERR_MASK 64'h0000000000000001
`define VXR_CTL_RESET 5'h00
`define VXR_EOI_OFFSET 8'h0b
`define VXR_MAX_CLUSTER 16'h0040
`define VXR_MAX_PHYS 16'h0200
`define VXR_CAUSE_BAD_TYPE 32'h00000000
`define VXR_CAUSE_NOT_RUN 32'h00000001
`define VXR_CAUSE_BAD_TGT 32'h00000002
`define VXR_CAUSE_BAD_PAGE 32'h00000003
`endif

/* File: verilog/vxr_pkg.sv */
// types of the virtualization exit-information and control register bank
// assumes the defines header is compiled alongside
package vxr_pkg;
   typedef enum logic [1:0] {VXR_EXIT_NONE, VXR_EXIT_IPI, VXR_EXIT_NOACCEL} vxr_exit_e;
   // failed interrupt delivery report from the delivery engine
   typedef struct packed {
      logic valid;
      logic [31:0] cmd_high;
      logic [31:0] cmd_low;
      logic level_trig;
      logic bad_dest_type;
      logic logical_mode;
      logic shorthand;
      logic [15:0] target;
      logic entry_missing;
      logic bad_page;
      logic not_running;
      logic [7:0] entry_index;
   } vxr_ipi_fail_s;
   // un-accelerated guest access report
   typedef struct packed {
      logic valid;
      logic is_write;
      logic [7:0] offset_hi;
      logic eoi_level;
      logic [7:0] isr_top_vector;
   } vxr_noaccel_s;
   // register state
   typedef struct packed {
      logic [4:0] ctl;
      logic nerr;
      logic [63:0] info1;
      logic [63:0] info2;
      vxr_exit_e exit_kind;
      logic exit_pulse;
      logic fault;
      logic [63:0] rdata;
      logic rvalid;
   } vxr_state_s;
endpackage

/* File: dv/vxr_regs_sva.sv */
// assertions on the virtualization exit and control register bank
// assumes it is bound to vxr_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "vxr_defines.svh"
module vxr_regs_sva
(
   // clock, reset and access port
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_addr,
   input wire logic [63:0] i_reg_wdata,
   input wire logic o_reg_rvalid,
   input wire logic o_protection_fault,
   // exits and levels
   input wire logic i_virt_enable_bit,
   input wire vxr_pkg::vxr_ipi_fail_s i_ipi_fail,
   input wire vxr_pkg::vxr_noaccel_s i_noaccel,
   input wire logic o_exit_valid,
   input wire logic [1:0] o_exit_kind,
   input wire logic [63:0] o_exit_detail_first,
   input wire logic [63:0] o_exit_detail_second,
   input wire logic o_debug_disable,
   input wire logic o_addr_wrap_mask_off,
   input wire logic o_virt_enable_mbz
);
   // a disable set while enabled is refused whole, so it must not count as a legal write
   wire logic ctl_wr = i_reg_wr && i_reg_addr == `VXR_ADDR_GLOBAL_CTL;
   wire logic dis_bad = i_reg_wdata[4] && i_virt_enable_bit && !o_virt_enable_mbz;
   wire logic ctl_ok = ctl_wr && i_reg_wdata[63:5] == 59'h0 && !dis_bad;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_rd; i_reg_rd |=> o_reg_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read answer missing");
   property p_ipi; i_ipi_fail.valid |=> o_exit_valid && o_exit_kind == 2'h1
      && o_exit_detail_first == {$past(i_ipi_fail.cmd_high), $past(i_ipi_fail.cmd_low)}; endproperty
   a_ipi: assert property (p_ipi) else $error("ipi first word wrong");
   property p_lvl; i_ipi_fail.valid && i_ipi_fail.level_trig |=> o_exit_detail_second == 64'h0; endproperty
   a_lvl: assert property (p_lvl) else $error("cause zero wrong");
   property p_na; i_noaccel.valid && !i_ipi_fail.valid |=> o_exit_kind == 2'h2 && o_exit_detail_first ==
      {31'h0, $past(i_noaccel.is_write), 20'h0, $past(i_noaccel.offset_hi), 4'h0}; endproperty
   a_na: assert property (p_na) else $error("access word wrong");
   property p_rsv; o_exit_valid && o_exit_kind == 2'h1 |-> o_exit_detail_second[31:8] == 24'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_dis; ctl_wr && dis_bad |=> o_protection_fault && !o_virt_enable_mbz; endproperty
   a_dis: assert property (p_dis) else $error("disable while enabled");
   property p_dbg; ctl_ok |=> o_debug_disable == $past(i_reg_wdata[0])
      && o_addr_wrap_mask_off == $past(i_reg_wdata[2]) && !o_protection_fault; endproperty
   a_dbg: assert property (p_dbg) else $error("control bits not taken");
   property p_mbz; ctl_wr && i_reg_wdata[5] |=> o_protection_fault; endproperty
   a_mbz: assert property (p_mbz) else $error("must be zero write");
endmodule
bind vxr_regs vxr_regs_sva u_sva (.*);
`default_nettype wire

/* File: dv/vxr_regs_tb.sv */
// self-checking bench of the virtualization exit and control register bank
// assumes vxr_regs and its checker are compiled ahead of it
`timescale 1ns/1ps
`default_nettype none
`include "vxr_defines.svh"
module vxr_regs_tb;
   logic clk = 0, rst = 1, wr = 0, rd = 0, en = 0, ini = 0, sin = 0, key = 0, rv, flt, xv, dbg, rin, a20, mbz, nei;
   logic [31:0] addr = 32'h0;
   logic [63:0] wd = 64'h0, rdat, x1, x2;
   logic [1:0] xk;
   vxr_pkg::vxr_ipi_fail_s ipi = '0, ipn;
   vxr_pkg::vxr_noaccel_s na = '0, nan;
   int mismatches = 0, check_count = 0, cyc = 0;
   // control writes: data, enable bit, {mbz,a20,rinit,dbg}, fault; the last two run locked
   logic [69:0] rows [6] = '{{64'h7, 1'h0, 4'h7, 1'h0}, {64'h10, 1'h1, 4'h7, 1'h1}, {64'h27, 1'h0, 4'h7, 1'h1},
      {64'h18, 1'h0, 4'h8, 1'h0}, {64'h1f, 1'h1, 4'hf, 1'h0}, {64'h0, 1'h0, 4'h8, 1'h0}};
   vxr_regs u_dut (.i_sys_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_protection_fault(flt),
      .i_virt_enable_bit(en), .i_init_event(ini), .i_secure_init_instr(sin), .i_key_unlock(key),
      .i_ipi_fail(ipi), .i_noaccel(na), .o_exit_valid(xv), .o_exit_kind(xk), .o_exit_detail_first(x1),
      .o_exit_detail_second(x2), .o_debug_disable(dbg), .o_init_redirect(rin), .o_addr_wrap_mask_off(a20),
      .o_virt_enable_mbz(mbz), .o_numeric_error_ignore(nei));
   //--------------------------------------
   // helpers
   //--------------------------------------
   initial forever #5 clk = ~clk;
   task chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one strobe, answer looked at in the cycle after it
   task acc(input logic w, input logic [31:0] a, input logic [63:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 0;
      rd <= 0;
      #1;
   endtask
   task ex(input logic [1:0] k, input logic [63:0] f, input logic [63:0] s);
      @(posedge clk);
      ipi <= ipn;
      na <= nan;
      @(posedge clk);
      ipi <= '0;
      na <= '0;
      #1 chk({xv, xk, x1, x2[31:0]}, {1'h1, k, f, s[31:0]});
      chk(x2, s);
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 0;
      #1 chk({dbg, rin, a20, mbz, nei, xv, rv, flt}, 8'h0);
      foreach (rows[i])
      begin
         @(posedge clk) en <= rows[i][5];
         acc(1, `VXR_ADDR_GLOBAL_CTL, rows[i][69:6]);
         chk({mbz, a20, rin, dbg, flt}, rows[i][4:0]);
      end
      en <= 0;
      acc(0, `VXR_ADDR_GLOBAL_CTL, 64'h0);
      chk({rv, rdat}, {1'h1, 64'h18});
      @(posedge clk) ini <= 1;
      sin <= 1;
      @(posedge clk) ini <= 0;
      sin <= 0;
      @(posedge clk) key <= 1;
      #1 chk(mbz, 1);
      @(posedge clk) ini <= 1;
      key <= 0;
      @(posedge clk) ini <= 0;
      #1 chk(mbz, 0);
      acc(1, `VXR_ADDR_NERR_IGN, 64'h1);
      chk({flt, nei}, 2'h1);
      acc(1, `VXR_ADDR_NERR_IGN, 64'h2);
      chk({flt, nei}, 2'h3);
      acc(0, 32'hc0010116, 64'h0);
      chk({flt, rdat}, {1'h1, 64'h0});
      acc(1, `VXR_ADDR_GLOBAL_CTL, 64'h10);
      @(posedge clk) sin <= 1;
      @(posedge clk) sin <= 0;
      #1 chk(mbz, 1);
      ipn = '0;
      nan = '0;
      ipn.valid = 1;
      ipn.cmd_high = 32'h89abcdef;
      ipn.cmd_low = 32'h01234567;
      ipn.not_running = 1;
      ipn.entry_index = 8'h05;
      ipn.target = 16'h200;
      nan.valid = 1;
      ex(2'h1, 64'h89abcdef01234567, 64'h100000005);
      nan = '0;
      ipn.target = 16'h201;
      ex(2'h1, 64'h89abcdef01234567, 64'h200000005);
      ipn.target = 16'h41;
      ipn.logical_mode = 1;
      ex(2'h1, 64'h89abcdef01234567, 64'h200000005);
      ipn.target = 16'h0;
      ipn.bad_page = 1;
      ex(2'h1, 64'h89abcdef01234567, 64'h300000005);
      ipn.level_trig = 1;
      ex(2'h1, 64'h89abcdef01234567, 64'h0);
      ipn = '0;
      nan = '{1'h1, 1'h1, 8'h0b, 1'h1, 8'h31};
      ex(2'h2, 64'h1000000b0, 64'h31);
      nan = '{1'h1, 1'h0, 8'h30, 1'h0, 8'h31};
      ex(2'h2, 64'h300, 64'h0);
      @(posedge clk) rst <= 1;
      @(posedge clk) rst <= 0;
      #1 chk({dbg, rin, a20, mbz, nei, xv, rv, flt, xk}, 10'h0);
      chk(x1 | x2 | rdat, 64'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
